// ===== verilog/gipc_top.v
/*
 GPIO interrupt generation and pad control for a 30-pin user bank and a
 6-pin flash bank, with an AXI4-Lite register slave. Assumes pad inputs and
 function signals synchronous to aclk and an external function mux that
 uses the pin_fsel outputs.
*/
// Chosen here: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "gipc_map.vh"

module gipc_top #(
   parameter NFUNC = 10
) (
   input  wire               aclk,
   input  wire               aresetn,
   input  wire               ce,
   input  wire [11:0]        s_axi_awaddr,
   input  wire               s_axi_awvalid,
   output reg                s_axi_awready,
   input  wire [31:0]        s_axi_wdata,
   input  wire [3:0]         s_axi_wstrb,
   input  wire               s_axi_wvalid,
   output reg                s_axi_wready,
   output reg  [1:0]         s_axi_bresp,
   output reg                s_axi_bvalid,
   input  wire               s_axi_bready,
   input  wire [11:0]        s_axi_araddr,
   input  wire               s_axi_arvalid,
   output reg                s_axi_arready,
   output reg  [31:0]        s_axi_rdata,
   output reg  [1:0]         s_axi_rresp,
   output reg                s_axi_rvalid,
   input  wire               s_axi_rready,
   input  wire [35:0]        pin_in,
   output reg  [35:0]        pad_out,
   output reg  [35:0]        pad_oe_n,
   output wire [149:0]       pin_fsel,
   input  wire [29:0]        alt_out,
   input  wire [29:0]        alt_oe,
   output reg  [29:0]        alt_in,
   output reg  [NFUNC-1:0]   fn_in,
   input  wire [5:0]         xip_out,
   input  wire [5:0]         xip_oe,
   output reg  [5:0]         xip_in,
   output wire [71:0]        pad_drive,
   output wire [35:0]        pad_slew_fast,
   output wire [35:0]        pad_schmitt,
   output wire [35:0]        pad_pull_up,
   output wire [35:0]        pad_pull_down,
   output wire [35:0]        pad_in_en,
   output wire               vsel_user,
   output wire               vsel_flash,
   output reg  [2:0]         irq_user,
   output reg  [2:0]         irq_flash,
   output reg                dormant_wake
);

   localparam NP  = 36;
   localparam NU  = 30;
   localparam EVW = 160;

   reg  [NP-1:0]     in_q;
   reg  [NP-1:0]     in_prev;
   reg  [NP*5-1:0]   fsel;
   reg  [NP*8-1:0]   padc;
   reg  [1:0]        vsel;
   reg  [NP-1:0]     sw_out;
   reg  [NP-1:0]     sw_oe;
   reg  [3*EVW-1:0]  inte;
   reg  [3*EVW-1:0]  intf;
   reg  [EVW-1:0]    edge_q;
   reg  [11:0]       aw_addr;
   reg  [31:0]       w_data;
   reg  [3:0]        w_strb;

   wire [EVW-1:0]    ev;
   wire [EVW-1:0]    ev_set;
   wire [EVW-1:0]    ev_mask;
   wire [3*EVW-1:0]  stat;
   wire [NP-1:0]     next_out;
   wire [NP-1:0]     next_oe;
   wire [NFUNC*NU-1:0] fn_hit;

   // Address to {kind, destination, index}; low address bits ignored except at GIPC_FINTR and the two vsel registers, which need the exact address
   function [11:0] dec;
      input [11:0] a;
      begin
         dec = {`GIPC_K_NONE, 2'h0, 6'h00};
         if (a < `GIPC_UINTR) begin
            dec = {(a[2] ? `GIPC_K_PCTRL : `GIPC_K_PSTAT), 2'h0, 1'b0, a[7:3]};
         end else if (a < `GIPC_UDEST) begin
            dec = {`GIPC_K_INTR, 2'h0, 4'h0, a[3:2]};
         end else if (a < `GIPC_UDEST_END) begin
            if (a[5:4] != `GIPC_SUB_NONE)
               dec = {`GIPC_K_INTE + {2'h0, a[5:4]}, a[7:6], 4'h0, a[3:2]};
         end else if (a >= `GIPC_FPIN && a < `GIPC_FPIN_END) begin
            dec = {(a[2] ? `GIPC_K_PCTRL : `GIPC_K_PSTAT), 2'h0, `GIPC_NUSR + {3'h0, a[5:3]}};
         end else if (a == `GIPC_FINTR) begin
            dec = {`GIPC_K_INTR, 2'h0, `GIPC_FWORD};
         end else if (a >= `GIPC_FDEST && a < `GIPC_FDEST_END) begin
            if (a[3:2] != `GIPC_SUB_NONE)
               dec = {`GIPC_K_INTE + {2'h0, a[3:2]}, a[5:4], `GIPC_FWORD};
         end else if (a >= `GIPC_PAD && a < `GIPC_PAD_END) begin
            dec = {`GIPC_K_PAD, 2'h0, a[7:2]};
         end else if (a == `GIPC_VSEL_U || a == `GIPC_VSEL_F) begin
            dec = {`GIPC_K_VSEL, 2'h0, 5'h00, a[2]};
         end else if (a[11:5] == `GIPC_SW_PAGE && a[3:2] != `GIPC_SUB_NONE) begin
            dec = {`GIPC_K_SWOUT + {2'h0, a[3:2]}, 2'h0, 5'h00, a[4]};
         end
      end
   endfunction

   function [31:0] sw_word;
      input [NP-1:0] v;
      input          bank;
      begin
         sw_word = bank ? {26'h0, v[NP-1:NU]} : {2'h0, v[NU-1:0]};
      end
   endfunction

   function [31:0] rd;
      input [11:0] k;
      reg   [5:0]  i;
      reg   [1:0]  d;
      begin
         i = k[5:0];
         d = k[7:6];
         case (k[11:8])
            `GIPC_K_PSTAT: rd = {29'h0, in_q[i], ~pad_oe_n[i], pad_out[i]};
            `GIPC_K_PCTRL: rd = {27'h0, fsel[i*5 +: 5]};
            `GIPC_K_INTR:  rd = ev[i*32 +: 32];
            `GIPC_K_INTE:  rd = inte[d*EVW + i*32 +: 32];
            `GIPC_K_INTF:  rd = intf[d*EVW + i*32 +: 32];
            `GIPC_K_INTS:  rd = stat[d*EVW + i*32 +: 32];
            `GIPC_K_PAD:   rd = {24'h0, padc[i*8 +: 8]};
            `GIPC_K_VSEL:  rd = {31'h0, vsel[i[0]]};
            `GIPC_K_SWOUT: rd = sw_word(sw_out, i[0]);
            `GIPC_K_SWOE:  rd = sw_word(sw_oe, i[0]);
            `GIPC_K_SWIN:  rd = sw_word(in_q, i[0]);
            default:       rd = 32'h0;
         endcase
      end
   endfunction

   // Event slots: eight per word, user pins first, flash pins from word four
   genvar s;
   generate
      for (s = 0; s < EVW/4; s = s + 1) begin : g_slot
         localparam integer P = (s < NU) ? s : ((s >= 32 && s < 32 + NP - NU) ? s - 2 : -1);
         if (P >= 0) begin : g_pin
            assign ev[4*s +: 4]      = {edge_q[4*s+3], edge_q[4*s+2], in_q[P], ~in_q[P]};
            assign ev_set[4*s +: 4]  = {in_q[P] & ~in_prev[P], ~in_q[P] & in_prev[P], 2'h0};
            assign ev_mask[4*s +: 4] = 4'hf;
         end else begin : g_empty
            assign ev[4*s +: 4]      = 4'h0;
            assign ev_set[4*s +: 4]  = 4'h0;
            assign ev_mask[4*s +: 4] = 4'h0;
         end
      end
   endgenerate

   genvar d;
   generate
      for (d = 0; d < 3; d = d + 1) begin : g_dest
         // Force bits only count where a real event exists
         assign stat[d*EVW +: EVW] = (ev | (intf[d*EVW +: EVW] & ev_mask)) & inte[d*EVW +: EVW];
      end
   endgenerate

   genvar p;
   generate
      for (p = 0; p < NP; p = p + 1) begin : g_pad
         wire sw_sel = (fsel[p*5 +: 5] == `GIPC_FN_SW);
         wire fo;
         wire fe;
         if (p < NU) begin : g_user
            assign fo = alt_out[p];
            assign fe = alt_oe[p];
            assign pin_fsel[p*5 +: 5] = fsel[p*5 +: 5];
         end else begin : g_flash
            wire xsel = (fsel[p*5 +: 5] == `GIPC_FN_XIP);
            assign fo = xsel & xip_out[p-NU];
            assign fe = xsel & xip_oe[p-NU];
         end
         assign next_out[p] = sw_sel ? sw_out[p] : fo;
         assign next_oe[p]  = (sw_sel ? sw_oe[p] : fe) & ~padc[p*8+`GIPC_PAD_OD];
         assign pad_drive[2*p +: 2]  = padc[p*8+`GIPC_PAD_DRV +: 2];
         assign pad_slew_fast[p]     = padc[p*8+`GIPC_PAD_SLEW];
         assign pad_schmitt[p]       = padc[p*8+`GIPC_PAD_SMT];
         assign pad_pull_up[p]       = padc[p*8+`GIPC_PAD_PUE];
         assign pad_pull_down[p]     = padc[p*8+`GIPC_PAD_PDE];
         assign pad_in_en[p]         = padc[p*8+`GIPC_PAD_IE];
      end
   endgenerate

   genvar f;
   genvar q;
   generate
      for (f = 0; f < NFUNC; f = f + 1) begin : g_fn
         localparam [4:0] FC = f;
         for (q = 0; q < NU; q = q + 1) begin : g_hit
            assign fn_hit[f*NU+q] = in_q[q] & (fsel[q*5 +: 5] == FC);
         end
      end
   endgenerate

   assign vsel_user  = vsel[0];
   assign vsel_flash = vsel[1];

   // Bus decode and write data merge
   wire [11:0]   wdec  = dec(aw_addr);
   wire [11:0]   rdec  = dec(s_axi_araddr);
   wire [3:0]    wk    = wdec[11:8];
   wire [1:0]    wd    = wdec[7:6];
   wire [5:0]    wi    = wdec[5:0];
   wire [31:0]   bmask = {{8{w_strb[3]}}, {8{w_strb[2]}}, {8{w_strb[1]}}, {8{w_strb[0]}}};
   wire [31:0]   wv    = (rd(wdec) & ~bmask) | (w_data & bmask);
   wire          do_wr = ce & ~s_axi_awready & ~s_axi_wready & ~s_axi_bvalid;
   wire [EVW-1:0] clr  = (do_wr && wk == `GIPC_K_INTR) ?
                         ({128'h0, w_data & bmask} << {wi, 5'h00}) : {EVW{1'b0}};

   // Pin sampling, edge latch, outputs
   always @(posedge aclk) begin
      if (!aresetn) begin
         in_q         <= {NP{1'b0}};
         in_prev      <= {NP{1'b0}};
         edge_q       <= {EVW{1'b0}};
         pad_out      <= {NP{1'b0}};
         pad_oe_n     <= {NP{1'b1}};
         alt_in       <= {NU{1'b0}};
         xip_in       <= 6'h00;
         irq_user     <= 3'h0;
         irq_flash    <= 3'h0;
         dormant_wake <= 1'b0;
      end else if (ce) begin
         in_q         <= pin_in & pad_in_en;
         in_prev      <= in_q;
         // Set beats a clear written in the same cycle
         edge_q       <= (edge_q & ~clr) | ev_set;
         pad_out      <= next_out;
         pad_oe_n     <= ~next_oe;
         alt_in       <= in_q[NU-1:0];
         xip_in       <= in_q[NP-1:NU];
         irq_user     <= {|stat[2*EVW +: 128], |stat[EVW +: 128], |stat[0 +: 128]};
         irq_flash    <= {|stat[2*EVW+128 +: 32], |stat[EVW+128 +: 32], |stat[128 +: 32]};
         dormant_wake <= |stat[2*EVW +: EVW];
      end
   end

   // Function inputs: own process, the only driver of fn_in
   integer k;
   always @(posedge aclk) begin
      if (!aresetn) begin
         fn_in <= {NFUNC{1'b0}};
      end else if (ce) begin
         for (k = 0; k < NFUNC; k = k + 1)
            fn_in[k] <= |fn_hit[k*NU +: NU];
      end
   end

   // Register file
   integer j;
   always @(posedge aclk) begin
      if (!aresetn) begin
         for (j = 0; j < NP; j = j + 1) begin
            fsel[j*5 +: 5] <= (j < NU) ? `GIPC_FSEL_URST : `GIPC_FSEL_FRST;
            padc[j*8 +: 8] <= `GIPC_PAD_RST;
         end
         vsel   <= 2'h0;
         sw_out <= {NP{1'b0}};
         sw_oe  <= {NP{1'b0}};
         inte   <= {3*EVW{1'b0}};
         intf   <= {3*EVW{1'b0}};
      end else if (do_wr) begin
         case (wk)
            `GIPC_K_PCTRL: fsel[wi*5 +: 5] <= wv[4:0];
            `GIPC_K_INTE:  inte[wd*EVW + wi*32 +: 32] <= wv & ev_mask[wi*32 +: 32];
            `GIPC_K_INTF:  intf[wd*EVW + wi*32 +: 32] <= wv & ev_mask[wi*32 +: 32];
            `GIPC_K_PAD:   padc[wi*8 +: 8] <= wv[7:0];
            `GIPC_K_VSEL:  vsel[wi[0]] <= wv[0];
            `GIPC_K_SWOUT: begin
               if (wi[0])
                  sw_out[NP-1:NU] <= wv[NP-NU-1:0];
               else
                  sw_out[NU-1:0] <= wv[NU-1:0];
            end
            `GIPC_K_SWOE: begin
               if (wi[0])
                  sw_oe[NP-1:NU] <= wv[NP-NU-1:0];
               else
                  sw_oe[NU-1:0] <= wv[NU-1:0];
            end
            default: ;
         endcase
      end
   end

   // AXI4-Lite write channel: address and data taken in either order
   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b1;
         s_axi_wready  <= 1'b1;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= `GIPC_OKAY;
         aw_addr       <= 12'h000;
         w_data        <= 32'h0;
         w_strb        <= 4'h0;
      end else if (ce) begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_addr       <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_data       <= s_axi_wdata;
            w_strb       <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
         end
         if (do_wr) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (wk == `GIPC_K_NONE) ? `GIPC_SLVERR : `GIPC_OKAY;
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid  <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
         end
      end
   end

   // AXI4-Lite read channel: one read at a time, answer one cycle after take
   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0;
         s_axi_rresp   <= `GIPC_OKAY;
      end else if (ce) begin
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= rd(rdec);
            s_axi_rresp   <= (rdec[11:8] == `GIPC_K_NONE) ? `GIPC_SLVERR : `GIPC_OKAY;
         end
         if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
         end
      end
   end

   // Level events are combinational on in_q and never latched
   // (see ev above); the sampled pin feeds both level bits directly.
   // hold through the ev assignment in g_slot.

endmodule // gipc_top

// ===== inc/gipc_map.vh
/*
 Register offsets, field positions and reset values for the GPIO
 interrupt and pad control block. Assumes a 12-bit AXI4-Lite byte address.
*/
`ifndef GIPC_MAP_VH
`define GIPC_MAP_VH

// Byte offsets
`define GIPC_UINTR      12'h0f0
`define GIPC_UDEST      12'h100
`define GIPC_UDEST_END  12'h1c0
`define GIPC_FPIN       12'h200
`define GIPC_FPIN_END   12'h230
`define GIPC_FINTR      12'h230
`define GIPC_FDEST      12'h240
`define GIPC_FDEST_END  12'h270
`define GIPC_PAD        12'h300
`define GIPC_PAD_END    12'h390
`define GIPC_VSEL_U     12'h3a0
`define GIPC_VSEL_F     12'h3a4
`define GIPC_SW_PAGE    7'h20

// Decoded register kinds
`define GIPC_K_NONE     4'h0
`define GIPC_K_PSTAT    4'h1
`define GIPC_K_PCTRL    4'h2
`define GIPC_K_INTR     4'h3
`define GIPC_K_INTE     4'h4
`define GIPC_K_INTF     4'h5
`define GIPC_K_INTS     4'h6
`define GIPC_K_PAD      4'h7
`define GIPC_K_VSEL     4'h8
`define GIPC_K_SWOUT    4'h9
`define GIPC_K_SWOE     4'ha
`define GIPC_K_SWIN     4'hb

// Index values
`define GIPC_NUSR       6'h1e
`define GIPC_FWORD      6'h04
`define GIPC_SUB_NONE   2'h3

// Function select
`define GIPC_FN_SW      5'h05
`define GIPC_FN_XIP     5'h00
`define GIPC_FSEL_URST  5'h1f
`define GIPC_FSEL_FRST  5'h00

// Pad control fields
`define GIPC_PAD_RST    8'h56
`define GIPC_PAD_SLEW   0
`define GIPC_PAD_SMT    1
`define GIPC_PAD_PDE    2
`define GIPC_PAD_PUE    3
`define GIPC_PAD_DRV    4
`define GIPC_PAD_IE     6
`define GIPC_PAD_OD     7

// Bus responses
`define GIPC_OKAY       2'h0
`define GIPC_SLVERR     2'h2

`endif

// ===== sim/gipc_checker.sv
/*
 Port-level assertions for the GPIO interrupt and pad control block.
 Assumes ce held high by the bench and one aclk domain.
*/
`timescale 1ns/1ps

module gipc_checker (
   input wire          aclk,
   input wire          aresetn,
   input wire          ce,
   input wire          s_axi_awvalid,
   input wire          s_axi_awready,
   input wire          s_axi_wvalid,
   input wire          s_axi_wready,
   input wire [1:0]    s_axi_bresp,
   input wire          s_axi_bvalid,
   input wire          s_axi_bready,
   input wire          s_axi_arvalid,
   input wire          s_axi_arready,
   input wire [31:0]   s_axi_rdata,
   input wire [1:0]    s_axi_rresp,
   input wire          s_axi_rvalid,
   input wire          s_axi_rready,
   input wire [35:0]   pin_in,
   input wire [35:0]   pad_out,
   input wire [35:0]   pad_oe_n,
   input wire [149:0]  pin_fsel,
   input wire [29:0]   alt_out,
   input wire [29:0]   alt_oe,
   input wire [29:0]   alt_in,
   input wire [35:0]   pad_in_en
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   sequence wr_take;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && ce;
   endsequence
   sequence rd_take;
      s_axi_arvalid && s_axi_arready && ce;
   endsequence

   wr_resp_a: assert property (wr_take |-> ##2 s_axi_bvalid)
      else $error("write response not two cycles after take");
   b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped before taken");
   wr_busy_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write channels ready while response pending");
   rd_resp_a: assert property (rd_take |=> s_axi_rvalid)
      else $error("read data not one cycle after take");
   r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data changed before taken");
   pad_rst_a: assert property ($rose(aresetn) |-> (&pad_in_en) && (&pad_oe_n))
      else $error("pad not usable after reset");
   oe_src_a: assert property (!pad_oe_n[2] |-> $past(pin_fsel[14:10] == 5'h05 || alt_oe[2]))
      else $error("pin driven without software or function enable");
   out_mux_a: assert property ($past(aresetn) && $past(pin_fsel[4:0]) != 5'h05 |-> pad_out[0] == $past(alt_out[0]))
      else $error("pad data not from selected function");
   in_vis_a: assert property ($past(aresetn, 2) |-> alt_in[3] == $past(pin_in[3] & pad_in_en[3], 2))
      else $error("pad input not passed to function");
endmodule // gipc_checker

bind gipc_top gipc_checker chk (.aclk(aclk), .aresetn(aresetn), .ce(ce),
   .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
   .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
   .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
   .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
   .s_axi_rready(s_axi_rready), .pin_in(pin_in), .pad_out(pad_out), .pad_oe_n(pad_oe_n),
   .pin_fsel(pin_fsel), .alt_out(alt_out), .alt_oe(alt_oe), .alt_in(alt_in), .pad_in_en(pad_in_en));

// ===== sim/gipc_pin_model.sv
/*
 External circuitry on the 36 pads: pad driver, board driver, pulls.
 Assumes pad outputs registered on aclk.
*/
`timescale 1ns/1ps

module gipc_pin_model (
   input wire         aclk,
   input wire [35:0]  pad_out,
   input wire [35:0]  pad_oe_n,
   input wire [35:0]  pad_pull_up,
   input wire [35:0]  pad_pull_down,
   input wire [35:0]  ext_drive,
   input wire [35:0]  ext_level,
   output reg [35:0]  pin_in
);
   integer i;
   initial pin_in = 36'h0;
   always @(posedge aclk) begin
      for (i = 0; i < 36; i = i + 1) begin
         if (!pad_oe_n[i])
            pin_in[i] <= pad_out[i];
         else if (ext_drive[i])
            pin_in[i] <= ext_level[i];
         else if (pad_pull_up[i])
            pin_in[i] <= 1'b1;
         else if (pad_pull_down[i])
            pin_in[i] <= 1'b0;
         else
            pin_in[i] <= ~pin_in[i]; // Floating pad: no stable level
      end
   end
endmodule // gipc_pin_model

// ===== sim/gipc_top_tb.sv
/*
 Register-level tests of the GPIO interrupt and pad control block.
 Assumes the pin model on the pads and a 100 MHz aclk.
*/
`timescale 1ns/1ps

module gipc_top_tb;
   logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic [11:0] awaddr = 0, araddr = 0;
   logic [31:0] wdata = 0;
   logic [3:0]  wstrb = 4'hf;
   logic [35:0] ext_level = 0;
   logic [5:0]  xip_out = 6'h1a, xip_oe = 6'h3f;
   logic awready, wready, bvalid, arready, rvalid, vsel_user, vsel_flash, dormant_wake;
   logic [1:0]  bresp, rresp;
   logic [31:0] rdata;
   logic [35:0] pin_in, pad_out, pad_oe_n, slew, smt, pu, pd, ie;
   logic [149:0] fsel;
   logic [29:0] alt_in;
   logic [9:0]  fn_in;
   logic [5:0]  xip_in;
   logic [71:0] drv;
   logic [2:0]  irq_user, irq_flash;
   int error_cnt = 0, compares = 0;

   gipc_top dut (.aclk(aclk), .aresetn(aresetn), .ce(1'b1), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .pin_in(pin_in), .pad_out(pad_out), .pad_oe_n(pad_oe_n), .pin_fsel(fsel), .alt_out(30'h1),
      .alt_oe(30'h1), .alt_in(alt_in), .fn_in(fn_in), .xip_out(xip_out), .xip_oe(xip_oe),
      .xip_in(xip_in), .pad_drive(drv), .pad_slew_fast(slew), .pad_schmitt(smt), .pad_pull_up(pu),
      .pad_pull_down(pd), .pad_in_en(ie), .vsel_user(vsel_user), .vsel_flash(vsel_flash),
      .irq_user(irq_user), .irq_flash(irq_flash), .dormant_wake(dormant_wake));
   // Board drives pins 1, 3, 4 and 6; the rest float on their pulls
   gipc_pin_model pins (.aclk(aclk), .pad_out(pad_out), .pad_oe_n(pad_oe_n), .pad_pull_up(pu),
      .pad_pull_down(pd), .ext_drive(36'h5a), .ext_level(ext_level), .pin_in(pin_in));

   initial begin
      forever #5 aclk = ~aclk;
   end

   task chk(input string nm, input [31:0] e, input [31:0] g);
      compares++;
      if (g !== e) begin
         error_cnt++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask
   task tick(input int n);
      repeat (n) @(posedge aclk);
   endtask
   task wr(input [11:0] a, input [31:0] d, input [3:0] s = 4'hf, input [1:0] r = 2'h0);
      int n;
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      wstrb <= s;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      n = 0;
      do begin
         @(posedge aclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
         n++;
      end while (bvalid !== 1'b1 && n < 50);
      bready <= 1'b0;
      chk($sformatf("bresp %h", a), r, bresp);
   endtask
   task rd(input [11:0] a, input [31:0] m, input [31:0] e, input [1:0] r = 2'h0);
      int n;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      n = 0;
      do begin
         @(posedge aclk);
         if (arready) arvalid <= 1'b0;
         n++;
      end while (rvalid !== 1'b1 && n < 50);
      rready <= 1'b0;
      chk($sformatf("rdata %h", a), e, rdata & m);
      chk($sformatf("rresp %h", a), r, rresp);
   endtask
   // Force and enable edge-high of pin 0 of a bank towards destination d
   task frc(input int d, input b);
      logic [11:0] e;
      e = b ? 12'(12'h240 + 16 * d) : 12'(12'h100 + 64 * d);
      wr(e, 32'h8);
      wr(b ? e + 12'h4 : e + 12'h10, 32'h8);
      tick(4);
      rd(b ? e + 12'h8 : e + 12'h20, 32'hf, 32'h8);
      chk("irq", 32'h1 << d, b ? irq_flash : irq_user);
      chk("wake", d == 2, dormant_wake);
      wr(b ? e + 12'h4 : e + 12'h10, 0);
      wr(e, 0);
   endtask
   task give_verdict;
      $display("compares %0d error_cnt %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   initial begin
      repeat (4000) @(posedge aclk);
      error_cnt++;
      give_verdict;
   end

   initial begin
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      tick(2);
      rd(12'h300, 32'hff, 32'h56);
      rd(12'h004, 32'h1f, 32'h1f);
      rd(12'h204, 32'h1f, 32'h0);
      rd(12'h3a0, 32'h1, 32'h0);
      rd(12'h3fc, 32'h0, 32'h0, 2'h2);
      wr(12'h3f0, 32'h0, 4'hf, 2'h2);
      chk("pad0", 32'h1b, {drv[1:0], smt[0], pu[0], pd[0], ie[0]});
      chk("xip", 32'h680, {pad_out[35:30], pad_oe_n[35:30]});
      for (int k = 0; k < 4; k++) begin
         wr(12'h300, 32'h46 | (k << 4) | (k & 1));
         tick(2);
         chk("drive", 32'(k * 2 + (k & 1)), {drv[1:0], slew[0]});
      end
      wr(12'h300, 32'h0, 4'h0);
      rd(12'h300, 32'hff, 32'h77);
      $display("test reset and pads done");

      wr(12'h0f0, 32'hffffffff);
      wr(12'h230, 32'hffffffff);
      wr(12'h100, 32'hf0);
      tick(6);
      rd(12'h120, 32'hf0, 32'h10);
      ext_level[1] <= 1'b1;
      tick(6);
      rd(12'h0f0, 32'hf0, 32'ha0);
      ext_level[1] <= 1'b0;
      tick(6);
      rd(12'h0f0, 32'hf0, 32'hd0);
      wr(12'h0f0, 32'hf0);
      rd(12'h0f0, 32'hf0, 32'h10);
      wr(12'h100, 32'h80);
      tick(4);
      chk("irq idle", 32'h0, irq_user);
      ext_level[1] <= 1'b1;
      tick(6);
      chk("irq edge", 32'h1, irq_user);
      wr(12'h0f0, 32'h80);
      tick(4);
      chk("irq clear", 32'h0, irq_user);
      wr(12'h100, 32'h0);
      for (int d = 0; d < 3; d++) begin
         frc(d, 1'b0);
         frc(d, 1'b1);
      end
      $display("test events done");

      wr(12'h014, 32'h5);
      wr(12'h400, 32'h4);
      wr(12'h404, 32'h4);
      tick(4);
      chk("sw drive", 32'h2, {pad_out[2], pad_oe_n[2]});
      chk("fsel", 32'h5, fsel[14:10]);
      rd(12'h408, 32'h4, 32'h4);
      wr(12'h308, 32'hd6);
      tick(4);
      chk("od", 32'h1, pad_oe_n[2]);
      rd(12'h408, 32'h4, 32'h0);
      ext_level[3] <= 1'b1;
      tick(4);
      rd(12'h408, 32'h8, 32'h8);
      wr(12'h30c, 32'h16);
      tick(4);
      rd(12'h408, 32'h8, 32'h0);
      for (int j = 0; j < 6; j++)
         wr(12'(12'h204 + 8 * j), 32'h5);
      wr(12'h410, 32'h25);
      wr(12'h414, 32'h3f);
      tick(4);
      chk("flash sw", 32'h940, {pad_out[35:30], pad_oe_n[35:30]});
      chk("xip in", 32'h25, xip_in);
      rd(12'h418, 32'h3f, 32'h25);
      $display("test software pins done");

      wr(12'h024, 32'h2);
      wr(12'h034, 32'h2);
      ext_level[6] <= 1'b1;
      tick(4);
      chk("fn or", 32'h1, fn_in[2]);
      ext_level[6] <= 1'b0;
      tick(4);
      chk("fn low", 32'h0, fn_in[2]);
      wr(12'h3a0, 32'h1);
      wr(12'h3a4, 32'h1);
      tick(2);
      chk("vsel", 32'h3, {vsel_user, vsel_flash});
      $display("test routing done");
      give_verdict;
   end
endmodule // gipc_top_tb
